/* frame_parameter_page_sequencer.sv */
`timescale 1ns/1ns
module frame_parameter_page_sequencer
  import seq_pkg::*;
(
  input  wire logic                          mclk,              // System clock, 50 MHz.
  input  wire logic                          reset,             // Synchronous reset.
  input  wire logic                          hsel,              // AHB slave select.
  input  wire logic [31:0]                   haddr,             // AHB address.
  input  wire logic [1:0]                    htrans,            // AHB transfer type.
  input  wire logic                          hwrite,            // AHB write flag.
  input  wire logic [2:0]                    hsize,             // AHB transfer size.
  input  wire logic                          hready,            // AHB bus ready.
  input  wire logic [31:0]                   hwdata,            // AHB write data.
  output logic [31:0]                        hrdata,            // AHB read data.
  output logic                               hreadyout,         // AHB slave ready.
  output logic                               hresp,             // AHB response, OKAY.
  input  wire logic                          acquiring,         // Camera is acquiring.
  input  wire logic                          exposure_active,   // Exposure in progress.
  input  wire logic                          frame_begin_trigger, // Frame start pulse.
  input  wire logic [INPUT_COUNT-1:0]        input_pins,        // Asynchronous input pins.
  output logic [CTRL_COUNT*VALUE_W-1:0]      applied_values,    // Values used this frame.
  output logic [PAGE_W-1:0]                  active_page,       // Page now active.
  output logic                               nv_valid,          // Save word offered.
  output logic [PAGE_W-1:0]                  nv_page,           // Save word page.
  output logic [CTRL_IDX_W-1:0]              nv_ctrl,           // Save word control slot.
  output logic [VALUE_W-1:0]                 nv_data,           // Save word value.
  input  wire logic                          nv_ready           // Storage takes word.
);

  // Register state of the block, apart from the page store.
  typedef struct packed {
    fsm_e                          fsm;       // Save sequencer state.
    logic                          dph_wr;    // Write data phase pending.
    logic                          dph_rd;    // Read data phase pending.
    logic [7:0]                    dph_addr;  // Data phase offset.
    logic                          rd_wait;   // Read wait state done.
    logic [31:0]                   rdata;     // Read data register.
    logic                          en;        // Sequencer enabled.
    logic                          loop;      // Wrap at end page.
    logic [6:0]                    page_sel;  // Manual page or all pages.
    logic [PAGE_W-1:0]             iv_start;  // Interval start page.
    logic [PAGE_W-1:0]             iv_end;    // Interval end page.
    src_e                          adv_src;   // Advance source.
    src_e                          rew_src;   // Rewind source.
    logic [PORT_W-1:0]             adv_port;  // Advance input port.
    logic [PORT_W-1:0]             rew_port;  // Rewind input port.
    logic                          adv_edge;  // Advance edge detect.
    logic                          adv_inv;   // Advance invert.
    logic                          rew_edge;  // Rewind edge detect.
    logic                          rew_inv;   // Rewind invert.
    logic [CTRL_IDX_W-1:0]         param_idx; // Control slot for data access.
    logic [PAGE_W-1:0]             active;    // Active page.
    logic                          adv_pend;  // Advance latched.
    logic                          rew_pend;  // Rewind latched.
    logic                          started;   // Start page applied.
    logic [INPUT_COUNT-1:0]        pin_meta;  // First sync stage.
    logic [INPUT_COUNT-1:0]        pin_sync;  // Second sync stage.
    logic [1:0]                    pin_prev;  // Previous levels, advance and rewind.
    logic [PAGE_W-1:0]             save_page; // Save walk page.
    logic [CTRL_IDX_W-1:0]         save_idx;  // Save walk slot.
    logic [VALUE_W-1:0]            nv_word;   // Save word register.
    logic [CTRL_COUNT*VALUE_W-1:0] applied;   // Applied values.
  } state_s;

  state_s s_r;   // Registered state.
  state_s s_nxt; // Next state.

  // Page store: one packed row per page.
  logic [CTRL_COUNT*VALUE_W-1:0] mem [PAGE_COUNT];

  logic                  mem_we;    // Write one control.
  logic                  mem_all;   // Write hits every page.
  logic                  mem_init;  // Restore defaults.
  logic [PAGE_W-1:0]     mem_page;  // Target page.
  logic [CTRL_IDX_W-1:0] mem_idx;   // Target control slot.
  logic [VALUE_W-1:0]    mem_wdata; // Value written.

  // Pin or software or frame event; level mode fires while the input stays asserted.
  function automatic logic detect(input src_e sel, input logic lvl, input logic prev,
                                  input logic edge_mode, input logic sw,
                                  input logic frame);
    logic pin_ev;
    pin_ev = edge_mode ? (lvl & ~prev) : lvl;
    case (sel)
      SRC_PIN:   detect = pin_ev;
      SRC_SOFT:  detect = sw;
      SRC_FRAME: detect = frame;
      default:   detect = 1'b0;
    endcase
  endfunction

  // Next-state logic: bus slave, configuration, events, page walk and save walk.
  always_comb
  begin
    logic                  acc;
    logic                  wr;
    logic                  cfg_ok;
    logic                  live;
    logic                  serve;
    logic                  adv_ev;
    logic                  rew_ev;
    logic                  adv_lvl;
    logic                  rew_lvl;
    logic                  sw_adv;
    logic                  sw_rew;
    logic [PAGE_W-1:0]     manual;
    logic [PAGE_W-1:0]     np;
    logic [CTRL_IDX_W-1:0] ni;
    acc       = hsel & hready & htrans[1] & (hsize == 3'h2);
    s_nxt     = s_r;
    wr        = s_r.dph_wr;
    cfg_ok    = ~acquiring & (s_r.fsm == ST_IDLE);
    live      = acquiring & s_r.en;
    sw_adv    = 1'b0;
    sw_rew    = 1'b0;
    mem_we    = 1'b0;
    mem_all   = (s_r.page_sel == SEL_ALL);
    mem_init  = 1'b0;
    mem_page  = s_r.page_sel[PAGE_W-1:0];
    mem_idx   = s_r.param_idx;
    mem_wdata = hwdata[VALUE_W-1:0];
    manual    = mem_all ? '0 : s_r.page_sel[PAGE_W-1:0];
    np        = s_r.save_page;
    ni        = s_r.save_idx;
    serve     = 1'b0;
    adv_ev    = 1'b0;
    rew_ev    = 1'b0;
    adv_lvl   = 1'b0;
    rew_lvl   = 1'b0;

    // Input pins cross into the clock domain through two stages.
    s_nxt.pin_meta = input_pins;
    s_nxt.pin_sync = s_r.pin_meta;

    // Address phase is taken whenever the bus is ready; reads get one wait state
    // so the page store read sees every earlier write.
    if (hready)
    begin
      s_nxt.dph_wr   = acc & hwrite;
      s_nxt.dph_rd   = acc & ~hwrite;
      s_nxt.dph_addr = haddr[7:0];
      s_nxt.rd_wait  = 1'b0;
    end
    else if (s_r.dph_rd)
    begin
      s_nxt.rd_wait = 1'b1;
    end

    // Read mux, loaded in the wait cycle. Unmapped offsets read zero.
    if (s_r.dph_rd && !s_r.rd_wait)
    begin
      s_nxt.rdata = 32'h0000_0000;
      case (s_r.dph_addr)
        OFS_CONTROL:
        begin
          s_nxt.rdata[CTL_ENABLE_BIT] = s_r.en;
          s_nxt.rdata[CTL_LOOP_BIT]   = s_r.loop;
        end
        OFS_PAGE_SEL:
          s_nxt.rdata = mem_all ? 32'hffff_ffff : {26'h0, s_r.page_sel[PAGE_W-1:0]};
        OFS_INTERVAL:
        begin
          s_nxt.rdata[IV_START_LSB +: PAGE_W] = s_r.iv_start;
          s_nxt.rdata[IV_END_LSB +: PAGE_W]   = s_r.iv_end;
        end
        OFS_SOURCES:
        begin
          s_nxt.rdata[ADV_SRC_LSB +: 2]      = s_r.adv_src;
          s_nxt.rdata[ADV_PORT_LSB +: PORT_W] = s_r.adv_port;
          s_nxt.rdata[ADV_EDGE_BIT]          = s_r.adv_edge;
          s_nxt.rdata[ADV_INV_BIT]           = s_r.adv_inv;
          s_nxt.rdata[REW_SRC_LSB +: 2]      = s_r.rew_src;
          s_nxt.rdata[REW_PORT_LSB +: PORT_W] = s_r.rew_port;
          s_nxt.rdata[REW_EDGE_BIT]          = s_r.rew_edge;
          s_nxt.rdata[REW_INV_BIT]           = s_r.rew_inv;
        end
        OFS_STATUS:
        begin
          s_nxt.rdata[PAGE_W-1:0]     = s_r.active;
          s_nxt.rdata[ST_ADV_PEND_BIT] = s_r.adv_pend;
          s_nxt.rdata[ST_REW_PEND_BIT] = s_r.rew_pend;
          s_nxt.rdata[ST_SAVE_BIT]     = (s_r.fsm == ST_SAVE);
          s_nxt.rdata[ST_ACQ_BIT]      = acquiring;
        end
        OFS_PARAM_IDX:
          s_nxt.rdata[CTRL_IDX_W-1:0] = s_r.param_idx;
        OFS_PARAM_DATA:
          s_nxt.rdata[VALUE_W-1:0] = mem[manual][s_r.param_idx*VALUE_W +: VALUE_W];
        default:
          s_nxt.rdata = 32'h0000_0000;
      endcase
    end

    // Write data phase. Configuration writes while acquiring or saving are dropped.
    if (wr)
    begin
      case (s_r.dph_addr)
        OFS_CONTROL:
          if (cfg_ok)
          begin
            s_nxt.en   = hwdata[CTL_ENABLE_BIT];
            s_nxt.loop = hwdata[CTL_LOOP_BIT];
          end
        OFS_PAGE_SEL:
          if (cfg_ok && hwdata[31:PAGE_W] == 26'h0)
            s_nxt.page_sel = {1'b0, hwdata[PAGE_W-1:0]};
          else if (cfg_ok && hwdata == 32'hffff_ffff)
            s_nxt.page_sel = SEL_ALL;
        OFS_INTERVAL:
          if (cfg_ok)
          begin
            s_nxt.iv_start = hwdata[IV_START_LSB +: PAGE_W];
            s_nxt.iv_end   = hwdata[IV_END_LSB +: PAGE_W];
          end
        OFS_SOURCES:
          if (cfg_ok)
          begin
            s_nxt.adv_src  = src_e'(hwdata[ADV_SRC_LSB +: 2]);
            s_nxt.adv_port = hwdata[ADV_PORT_LSB +: PORT_W];
            s_nxt.adv_edge = hwdata[ADV_EDGE_BIT];
            s_nxt.adv_inv  = hwdata[ADV_INV_BIT];
            s_nxt.rew_port = hwdata[REW_PORT_LSB +: PORT_W];
            s_nxt.rew_edge = hwdata[REW_EDGE_BIT];
            s_nxt.rew_inv  = hwdata[REW_INV_BIT];
            if (hwdata[REW_SRC_LSB +: 2] == SRC_PIN || hwdata[REW_SRC_LSB +: 2] == SRC_SOFT)
              s_nxt.rew_src = src_e'(hwdata[REW_SRC_LSB +: 2]);
          end
        OFS_PARAM_IDX:
          if (hwdata[31:0] < 32'(CTRL_COUNT))
            s_nxt.param_idx = hwdata[CTRL_IDX_W-1:0];
        OFS_PARAM_DATA:
          mem_we = ~live & (s_r.fsm == ST_IDLE);
        OFS_COMMAND:
        begin
          mem_init = cfg_ok & hwdata[CMD_INIT_BIT];
          if (cfg_ok && hwdata[CMD_SAVE_BIT] && !hwdata[CMD_INIT_BIT])
          begin
            s_nxt.fsm       = ST_SAVE;
            s_nxt.save_page = '0;
            s_nxt.save_idx  = '0;
            s_nxt.nv_word   = mem[0][VALUE_W-1:0];
          end
          sw_adv = hwdata[CMD_ADV_BIT];
          sw_rew = hwdata[CMD_REW_BIT];
        end
        default:
          s_nxt.en = s_r.en;
      endcase
    end

    adv_lvl        = s_r.pin_sync[s_r.adv_port] ^ s_r.adv_inv;
    rew_lvl        = s_r.pin_sync[s_r.rew_port] ^ s_r.rew_inv;
    s_nxt.pin_prev = {rew_lvl, adv_lvl};
    adv_ev = detect(s_r.adv_src, adv_lvl, s_r.pin_prev[0], s_r.adv_edge, sw_adv,
                    frame_begin_trigger);
    rew_ev = detect(s_r.rew_src, rew_lvl, s_r.pin_prev[1], s_r.rew_edge, sw_rew,
                    1'b0);

    serve          = live & s_r.started & ~exposure_active;
    s_nxt.adv_pend = live & ((s_r.adv_pend & ~serve) | adv_ev);
    s_nxt.rew_pend = live & ((s_r.rew_pend & ~serve) | rew_ev);

    // While acquiring, the active page moves only outside exposure; a late start waits for the gap.
    if (!acquiring)
    begin
      s_nxt.started = 1'b0;
      s_nxt.active  = manual;
    end
    else if (!exposure_active)
    begin
      if (!s_r.started)
      begin
        s_nxt.started = 1'b1;
        s_nxt.active = s_r.en ? s_r.iv_start : manual;
      end
      else if (serve && s_r.rew_pend)
        s_nxt.active = s_r.iv_start;
      else if (serve && s_r.adv_pend)
      begin
        if (s_r.active == s_r.iv_end)
          s_nxt.active = s_r.loop ? s_r.iv_start : s_r.active;
        else
          s_nxt.active = PAGE_W'(s_r.active + 6'h1);
      end
    end

    if (!exposure_active)
      s_nxt.applied = mem[s_r.active];

    // Save walk: one word per storage handshake, page by page, slot by slot.
    case (s_r.fsm)
      // Idle keeps what the command write chose, so a save start is not lost here.
      ST_IDLE:
        s_nxt.fsm = s_nxt.fsm;
      ST_SAVE:
        if (nv_ready)
        begin
          if (s_r.save_idx == CTRL_IDX_W'(CTRL_COUNT - 1))
          begin
            ni = '0;
            np = PAGE_W'(s_r.save_page + 6'h1);
            if (s_r.save_page == PAGE_W'(PAGE_COUNT - 1))
              s_nxt.fsm = ST_IDLE;
          end
          else
            ni = CTRL_IDX_W'(s_r.save_idx + 4'h1);
          s_nxt.save_page = np;
          s_nxt.save_idx  = ni;
          s_nxt.nv_word   = mem[np][ni*VALUE_W +: VALUE_W];
        end
      default:
        s_nxt.fsm = ST_IDLE;
    endcase
  end

  // State register with synchronous reset to constants.
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      s_r           <= '0;
      s_r.fsm       <= ST_IDLE;
      s_r.page_sel  <= PAGE_SEL_RST;
      s_r.iv_start  <= IV_START_RST;
      s_r.iv_end    <= IV_END_RST;
      s_r.adv_src   <= SRC_PIN;
      s_r.rew_src   <= SRC_SOFT;
      s_r.param_idx <= PARAM_IDX_RST;
      s_r.applied   <= CTRL_DEFAULTS;
    end
    else
      s_r <= s_nxt;
  end

  // defaults at reset and init
  // Every page is a full register row so an all-pages write finishes in one cycle;
  // the cost is area, traded for a setup that never stalls the bus.
  always_ff @(posedge mclk)
  begin
    for (int p = 0; p < PAGE_COUNT; p++)
    begin
      if (reset || mem_init)
        mem[p] <= CTRL_DEFAULTS;
      else if (mem_we && (mem_all || mem_page == PAGE_W'(p)))
        mem[p][mem_idx*VALUE_W +: VALUE_W] <= mem_wdata;
    end
  end

  // Outputs.
  assign hrdata         = s_r.rdata;
  assign hreadyout      = ~(s_r.dph_rd & ~s_r.rd_wait);
  assign hresp          = 1'b0;
  assign applied_values = s_r.applied;
  assign active_page    = s_r.active;
  assign nv_valid       = (s_r.fsm == ST_SAVE);
  assign nv_page        = s_r.save_page;
  assign nv_ctrl        = s_r.save_idx;
  assign nv_data        = s_r.nv_word;

  // Helper terms read only by the checks below.
  logic serve_both; // Both requests served together.
  logic serve_adv;  // Advance served alone.
  assign serve_both = acquiring & s_r.en & s_r.started & ~exposure_active
                      & s_r.rew_pend & s_r.adv_pend;
  assign serve_adv  = acquiring & s_r.en & s_r.started & ~exposure_active
                      & ~s_r.rew_pend & s_r.adv_pend;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  a_page_hold_exposure: assert property (exposure_active |=> $stable(s_r.active))
    else $error("Active page changed during exposure.");
  a_rewind_over_advance: assert property (serve_both |=> s_r.active == $past(s_r.iv_start))
    else $error("Rewind did not win over advance.");
  a_advance_step: assert property (serve_adv && s_r.active != s_r.iv_end
    |=> s_r.active == $past(s_r.active) + 6'h1)
    else $error("Advance did not step by one.");
  a_end_wrap_hold: assert property (serve_adv && s_r.active == s_r.iv_end
    |=> s_r.active == ($past(s_r.loop) ? $past(s_r.iv_start) : $past(s_r.active)))
    else $error("End page wrap or hold wrong.");
  a_start_first: assert property (acquiring && s_r.en && !exposure_active && !s_r.started
    |=> s_r.active == $past(s_r.iv_start) && s_r.started)
    else $error("Acquisition did not start at interval start.");
  a_config_locked: assert property (acquiring ##1 acquiring
    |-> $stable(s_r.iv_start) && $stable(s_r.en) && $stable(s_r.page_sel))
    else $error("Configuration changed while acquiring.");
  a_page_sel_range: assert property (s_r.page_sel[6] == 1'b0 || s_r.page_sel == SEL_ALL)
    else $error("Page select out of range.");
  a_rewind_src_legal: assert property (s_r.rew_src != SRC_FRAME)
    else $error("Rewind source set to frame start.");
  a_seq_write_lock: assert property (acquiring && s_r.en |-> !mem_we)
    else $error("Sequenced control written while live.");
  a_save_walk_end: assert property (nv_valid && nv_ready && s_r.save_page == 6'h3f
    && s_r.save_idx == 4'hb |=> !nv_valid)
    else $error("Save walk did not end after last word.");

endmodule

/* seq_pkg.sv */
// Behaviour
// - Sixty-four pages of sequenced control values.
// - Power-on and init restore page defaults.
// - Save copies every page to non-volatile storage.
// - Page minus one writes all pages.
// - Configuration accepted only while not acquiring.
// - Sequenced controls locked while sequencing live.
// - No direct page change during plain acquisition.
// - Disabled sequencer uses manually selected page.
// - Enabled sequencer starts at interval start page.
// - Advance event moves page forward by one.
// - At end page wrap if loop, else hold.
// - Rewind event returns to interval start page.
// - Advance source: pin, software or frame start.
// - Rewind source frame start is rejected.
// - Pin source: port, edge/level, optional inversion.
// - Page never changes during exposure; requests latched. Held only while acquiring; otherwise it follows the manual page.
// - New page values applied between frames.
// - Only the twelve listed controls are sequenced.
// - Pending rewind wins over pending advance.
package seq_pkg;

  // Sizes of the page store and the input pins.
  localparam int PAGE_COUNT  = 64;
  localparam int PAGE_W      = 6;
  localparam int CTRL_COUNT  = 12;
  localparam int CTRL_IDX_W  = 4;
  localparam int VALUE_W     = 16;
  localparam int INPUT_COUNT = 4;
  localparam int PORT_W      = 2;

  // Register byte offsets, decoded on the low address byte.
  localparam logic [7:0] OFS_CONTROL    = 8'h00;
  localparam logic [7:0] OFS_PAGE_SEL   = 8'h04;
  localparam logic [7:0] OFS_INTERVAL   = 8'h08;
  localparam logic [7:0] OFS_SOURCES    = 8'h0c;
  localparam logic [7:0] OFS_COMMAND    = 8'h10;
  localparam logic [7:0] OFS_STATUS     = 8'h14;
  localparam logic [7:0] OFS_PARAM_IDX  = 8'h18;
  localparam logic [7:0] OFS_PARAM_DATA = 8'h1c;

  // Field positions.
  localparam int CTL_ENABLE_BIT  = 0;
  localparam int CTL_LOOP_BIT    = 1;
  localparam int IV_START_LSB    = 0;
  localparam int IV_END_LSB      = 8;
  localparam int ADV_SRC_LSB     = 0;
  localparam int ADV_PORT_LSB    = 2;
  localparam int ADV_EDGE_BIT    = 4;
  localparam int ADV_INV_BIT     = 5;
  localparam int REW_SRC_LSB     = 8;
  localparam int REW_PORT_LSB    = 10;
  localparam int REW_EDGE_BIT    = 12;
  localparam int REW_INV_BIT     = 13;
  localparam int CMD_INIT_BIT    = 0;
  localparam int CMD_SAVE_BIT    = 1;
  localparam int CMD_ADV_BIT     = 2;
  localparam int CMD_REW_BIT     = 3;
  localparam int ST_ADV_PEND_BIT = 8;
  localparam int ST_REW_PEND_BIT = 9;
  localparam int ST_SAVE_BIT     = 10;
  localparam int ST_ACQ_BIT      = 11;

  // Page select code meaning all pages, and reset values.
  localparam logic [6:0]  SEL_ALL       = 7'h7f;
  localparam logic [6:0]  PAGE_SEL_RST  = 7'h00;
  localparam logic [5:0]  IV_START_RST  = 6'h00;
  localparam logic [5:0]  IV_END_RST    = 6'h00;
  localparam logic [3:0]  PARAM_IDX_RST = 4'h0;

  // Control defaults, lowest slot first: shutter, frame rate, gain, digital gain,
  // start X, start Y, white balance, brightness, contrast, saturation, sharpness,
  // output ports. Digital gain default is unity.
  localparam logic [CTRL_COUNT*VALUE_W-1:0] CTRL_DEFAULTS = {
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0400, 16'h0000, 16'h0000, 16'h0000};

  // Event sources.
  typedef enum logic [1:0] {SRC_PIN = 2'h0, SRC_SOFT = 2'h1, SRC_FRAME = 2'h2} src_e;

  // Save sequencer states.
  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_SAVE = 2'b10} fsm_e;

endpackage

/* nv_store.sv */
`timescale 1ns/1ns
module nv_store
(
  input  wire logic        mclk,     // System clock.
  input  wire logic        reset,    // Synchronous reset.
  input  wire logic        nv_valid, // Save word offered.
  input  wire logic        slow,     // Stall every other cycle.
  output logic             nv_ready, // Storage takes word.
  output logic [15:0]      words     // Words taken so far.
);
  // Storage takes a word at every valid and ready edge.
  // A slow store drops ready on alternate cycles to stress the walk.
  // counts saved words
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      nv_ready <= 1'b0;
      words    <= 16'h0000;
    end
    else
    begin
      if (nv_valid && nv_ready)
        words <= words + 16'h0001;
      nv_ready <= slow ? ~nv_ready : 1'b1;
    end
  end
endmodule

/* frame_parameter_page_sequencer_tb_top.sv */
`timescale 1ns/1ns
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin bad_count++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end
module frame_parameter_page_sequencer_tb_top
  import seq_pkg::*;
;
  logic mclk, reset, hsel, hwrite, acq, expo, nv_valid, nv_ready, hreadyout;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [5:0]  active_page;
  logic [15:0] words, nv_data;
  logic [5:0]  nv_page;
  logic [3:0]  pins, nv_ctrl;
  logic        frame, hresp;
  logic [191:0] applied_values;
  int bad_count, num_checks, n;

  frame_parameter_page_sequencer i_frame_parameter_page_sequencer (.mclk(mclk),
    .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .acquiring(acq), .exposure_active(expo),
    .frame_begin_trigger(frame), .input_pins(pins), .applied_values(applied_values),
    .active_page(active_page), .nv_valid(nv_valid), .nv_page(nv_page),
    .nv_ctrl(nv_ctrl), .nv_data(nv_data), .nv_ready(nv_ready));
  nv_store i_nv_store (.mclk(mclk), .reset(reset), .nv_valid(nv_valid), .slow(1'b1),
    .nv_ready(nv_ready), .words(words));

  // Free-running 50 MHz clock.
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // One AHB-Lite single word transfer; waits on hready in both phases.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize  <= 3'h2;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h00000000);
    `CHK(q, e)
  endtask

  // Single exit point for the run.
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Watchdog; the whole sequence needs only a few thousand cycles.
  initial
  begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    conclude();
  end

  initial
  begin
    {reset, hsel, hwrite, acq, expo} = 5'h10;
    {haddr, hwdata, htrans, hsize, pins, frame} = '0;
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    `CHK(active_page, 6'h00)
    `CHK(applied_values[63:48], 16'h0400)
    wr(OFS_PAGE_SEL, 32'hffffffff);
    wr(OFS_PARAM_IDX, 32'h00000000);
    wr(OFS_PARAM_DATA, 32'h00001234);
    wr(OFS_PAGE_SEL, 32'h00000005);
    wr(OFS_PARAM_DATA, 32'h00000055);
    rd(OFS_PARAM_DATA, 32'h00000055);
    wr(OFS_PAGE_SEL, 32'h00000003);
    rd(OFS_PARAM_DATA, 32'h00001234);
    wr(OFS_PAGE_SEL, 32'h00000040);
    rd(OFS_PAGE_SEL, 32'h00000003);
    rd(8'h40, 32'h00000000);
    $display("test page store done");
    wr(OFS_SOURCES, 32'h00000201);
    rd(OFS_SOURCES, 32'h00000101);
    wr(OFS_INTERVAL, 32'h00000302);
    wr(OFS_CONTROL, 32'h00000003);
    acq <= 1'b1;
    wr(OFS_INTERVAL, 32'h00000000);
    `CHK(hresp, 1'b0)
    rd(OFS_INTERVAL, 32'h00000302);
    rd(OFS_STATUS, 32'h00000802);
    `CHK(applied_values[15:0], 16'h1234)
    wr(OFS_COMMAND, 32'h00000004);
    rd(OFS_STATUS, 32'h00000803);
    wr(OFS_COMMAND, 32'h00000004);
    rd(OFS_STATUS, 32'h00000802);
    wr(OFS_COMMAND, 32'h00000004);
    expo <= 1'b1;
    wr(OFS_COMMAND, 32'h00000004);
    wr(OFS_COMMAND, 32'h00000008);
    rd(OFS_STATUS, 32'h00000b02);
    expo <= 1'b0;
    rd(OFS_STATUS, 32'h00000802);
    wr(OFS_PARAM_DATA, 32'h00000077);
    rd(OFS_PARAM_DATA, 32'h00001234);
    acq <= 1'b0;
    rd(OFS_STATUS, 32'h00000003);
    // Inverted edge on pin 1: one falling edge must give exactly one advance.
    pins <= 4'h2;
    wr(OFS_SOURCES, 32'h00000134);
    acq <= 1'b1;
    repeat (4) @(posedge mclk);
    pins <= 4'h0;
    repeat (8) @(posedge mclk);
    `CHK(active_page, 6'h03)
    acq <= 1'b0;
    wr(OFS_SOURCES, 32'h00000102);
    acq <= 1'b1;
    repeat (4) @(posedge mclk);
    frame <= 1'b1;
    @(posedge mclk);
    frame <= 1'b0;
    repeat (4) @(posedge mclk);
    `CHK(active_page, 6'h03)
    wr(OFS_COMMAND, 32'h00000008);
    rd(OFS_STATUS, 32'h00000802);
    acq <= 1'b0;
    wr(OFS_CONTROL, 32'h00000000);
    acq <= 1'b1;
    wr(OFS_PAGE_SEL, 32'h00000005);
    rd(OFS_STATUS, 32'h00000803);
    rd(OFS_PAGE_SEL, 32'h00000003);
    acq <= 1'b0;
    $display("test sequencing done");
    wr(OFS_COMMAND, 32'h00000002);
    @(posedge mclk);
    `CHK(nv_data, 16'h1234)
    `CHK({nv_page, nv_ctrl}, 10'h000)
    n = 0;
    while (nv_valid !== 1'b0 || n < 4)
    begin
      @(posedge mclk);
      n++;
    end
    `CHK(words, 16'd768)
    $display("test save done");
    conclude();
  end
endmodule
